// ===== mio_map.svh
`ifndef MIO_MAP_SVH
`define MIO_MAP_SVH

// Register indexes; byte address is four times the index
`define MIO_IDX_PORT4_LATCH     20'hfff04
`define MIO_IDX_PORT5_LATCH     20'hfff05
`define MIO_IDX_PORT7_LATCH     20'hfff07
`define MIO_IDX_PORT4_DIR       20'hfff24
`define MIO_IDX_PORT5_DIR       20'hfff25
`define MIO_IDX_PORT7_DIR       20'hfff27
`define MIO_IDX_PORT4_PULLUP    20'hfff40
`define MIO_IDX_PORT5_PULLUP    20'hfff41
`define MIO_IDX_PORT7_PULLUP    20'hfff43
`define MIO_IDX_PORT4_ANALOG    20'hfff44
`define MIO_IDX_PORT5_ANALOG    20'hfff45
`define MIO_IDX_PORT7_ANALOG    20'hfff47
`define MIO_IDX_PORT5_OPEN_DRN  20'hfff48
`define MIO_IDX_IRQ_EDGE        20'hfff49
`define MIO_IDX_IRQ_STATUS      20'hfff4a
`define MIO_IDX_IRQ_MASK        20'hfff4b

// Implemented bits per register
`define MIO_PORT4_IMPL          8'h07
`define MIO_PORT5_IMPL          8'h03
`define MIO_PORT7_IMPL          8'h0f
`define MIO_PORT4_ANA_IMPL      8'h02
`define MIO_PORT5_ANA_IMPL      8'h03
`define MIO_PORT7_ANA_IMPL      8'h01
`define MIO_PORT5_OD_IMPL       8'h01
`define MIO_EDGE_IMPL           8'h0f
`define MIO_IRQ_IMPL            8'h03

// Reset values
`define MIO_DIR_RESET           8'hff
`define MIO_LATCH_RESET         8'h00
`define MIO_CFG_RESET           8'h00

// Edge select field: bit 0 rising, bit 1 falling, per pin
`define MIO_EDGE_RISE_BIT       0
`define MIO_EDGE_FALL_BIT       1
`define MIO_EDGE_FIELD_W        2

`endif

// ===== mio_pkg.sv
package mio_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
  } mio_addr_phase_type;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pu;
  } mio_drive_type;

  typedef enum logic [1:0] {
    MIO_BUS_IDLE,
    MIO_BUS_WRITE,
    MIO_BUS_READ
  } mio_bus_state_type;

endpackage

// ===== mio_pin_sync.sv
`timescale 1ns/100ps

module mio_pin_sync #(
  parameter int W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule

// ===== mio_edge_irq.sv
`timescale 1ns/100ps
`include "mio_map.svh"

module mio_edge_irq #(
  parameter int N = 2
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic [N-1:0]                   level,
  input  wire logic [N*`MIO_EDGE_FIELD_W-1:0] edge_sel,
  output logic      [N-1:0]                   event_pulse
);

  logic [N-1:0] prev_q;
  logic [N-1:0] event_q;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          prev_q[i]  <= 1'b0;
          event_q[i] <= 1'b0;
        end else begin
          prev_q[i]  <= level[i];
          event_q[i] <= (level[i] & ~prev_q[i] & edge_sel[i*`MIO_EDGE_FIELD_W+`MIO_EDGE_RISE_BIT]) |
                        (~level[i] & prev_q[i] & edge_sel[i*`MIO_EDGE_FIELD_W+`MIO_EDGE_FALL_BIT]);
        end
      end
    end
  endgenerate

  assign event_pulse = event_q;

endmodule

// ===== mio_ports.sv
`timescale 1ns/100ps
`include "mio_map.svh"

module mio_ports
  import mio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  input  wire logic [2:0]  port4_pin_in,
  output logic      [2:0]  port4_pin_out,
  output logic      [2:0]  port4_pin_oe,
  output logic      [2:0]  port4_pullup_en,
  output logic      [2:0]  port4_analog_en,
  input  wire logic [1:0]  port5_pin_in,
  output logic      [1:0]  port5_pin_out,
  output logic      [1:0]  port5_pin_oe,
  output logic      [1:0]  port5_pullup_en,
  output logic      [1:0]  port5_analog_en,
  input  wire logic [3:0]  port7_pin_in,
  output logic      [3:0]  port7_pin_out,
  output logic      [3:0]  port7_pin_oe,
  output logic      [3:0]  port7_pullup_en,
  output logic      [3:0]  port7_analog_en
);

  function automatic logic addr_is(input logic [31:0] a, input logic [19:0] idx);
    return a == {10'h000, idx, 2'b00};
  endfunction

  // Open drain: latch high releases the pin instead of driving it
  function automatic mio_drive_type pin_drive(input logic [7:0] dir, input logic [7:0] ana,
                                              input logic [7:0] lat, input logic [7:0] od,
                                              input logic [7:0] pu);
    mio_drive_type d;
    d.oe  = ~dir & ~ana & ~(od & lat);
    d.out = lat & ~od;
    d.pu  = pu & dir & ~ana;
    return d;
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] din,
                                           input logic [7:0] lat);
    return (dir & din) | (~dir & lat);
  endfunction

  mio_bus_state_type  state_q;
  mio_addr_phase_type cap_q;
  logic               accept;
  logic               wr_en;
  logic [7:0]         wd;
  logic [7:0]         rd_d;
  logic [31:0]        hrdata_q;
  logic               hreadyout_q;
  logic               hresp_q;

  logic [7:0] latch4_q;
  logic [7:0] latch5_q;
  logic [7:0] latch7_q;
  logic [7:0] dir4_q;
  logic [7:0] dir5_q;
  logic [7:0] dir7_q;
  logic [7:0] pull4_q;
  logic [7:0] pull5_q;
  logic [7:0] pull7_q;
  logic [7:0] ana4_q;
  logic [7:0] ana5_q;
  logic [7:0] ana7_q;
  logic [7:0] od5_q;
  logic [7:0] edge_q;
  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [7:0] stat_clr;
  logic       irq_q;

  logic [8:0]    pin_sync;
  logic [7:0]    din4;
  logic [7:0]    din5;
  logic [7:0]    din7;
  logic [1:0]    port5_event;
  mio_drive_type drv4;
  mio_drive_type drv5;
  mio_drive_type drv7;

  logic [2:0] port4_out_q;
  logic [2:0] port4_oe_q;
  logic [2:0] port4_pu_q;
  logic [2:0] port4_ana_q;
  logic [1:0] port5_out_q;
  logic [1:0] port5_oe_q;
  logic [1:0] port5_pu_q;
  logic [1:0] port5_ana_q;
  logic [3:0] port7_out_q;
  logic [3:0] port7_oe_q;
  logic [3:0] port7_pu_q;
  logic [3:0] port7_ana_q;

  // Bus slave: writes take no wait state, reads one so the data come from a flop
  assign accept = hsel && hready && htrans[1];
  assign wr_en  = (state_q == MIO_BUS_WRITE) && cap_q.write;
  assign wd     = hwdata[7:0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q     <= MIO_BUS_IDLE;
      cap_q       <= '0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      hrdata_q    <= '0;
    end else begin
      case (state_q)
        MIO_BUS_READ: begin
          hrdata_q    <= {24'h000000, rd_d};
          hreadyout_q <= 1'b1;
          state_q     <= MIO_BUS_IDLE;
        end
        default: begin
          if (accept) begin
            cap_q       <= '{addr: haddr, write: hwrite};
            state_q     <= hwrite ? MIO_BUS_WRITE : MIO_BUS_READ;
            hreadyout_q <= hwrite;
          end else begin
            state_q     <= MIO_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    if (addr_is(cap_q.addr, `MIO_IDX_PORT4_LATCH)) begin
      rd_d = port_read(dir4_q, din4, latch4_q);
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT5_LATCH)) begin
      rd_d = port_read(dir5_q, din5, latch5_q);
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT7_LATCH)) begin
      rd_d = port_read(dir7_q, din7, latch7_q);
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT4_DIR)) begin
      rd_d = dir4_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT5_DIR)) begin
      rd_d = dir5_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT7_DIR)) begin
      rd_d = dir7_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT4_PULLUP)) begin
      rd_d = pull4_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT5_PULLUP)) begin
      rd_d = pull5_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT7_PULLUP)) begin
      rd_d = pull7_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT4_ANALOG)) begin
      rd_d = ana4_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT5_ANALOG)) begin
      rd_d = ana5_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT7_ANALOG)) begin
      rd_d = ana7_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_PORT5_OPEN_DRN)) begin
      rd_d = od5_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_IRQ_EDGE)) begin
      rd_d = edge_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_IRQ_STATUS)) begin
      rd_d = stat_q;
    end else if (addr_is(cap_q.addr, `MIO_IDX_IRQ_MASK)) begin
      rd_d = mask_q;
    end else begin
      rd_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latch4_q <= `MIO_LATCH_RESET;
      latch5_q <= `MIO_LATCH_RESET;
      latch7_q <= `MIO_LATCH_RESET;
    end else if (wr_en) begin
      if (addr_is(cap_q.addr, `MIO_IDX_PORT4_LATCH)) latch4_q <= wd & `MIO_PORT4_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT5_LATCH)) latch5_q <= wd & `MIO_PORT5_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT7_LATCH)) latch7_q <= wd & `MIO_PORT7_IMPL;
    end
  end

  // Direction bit high means input; missing pins stay input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir4_q <= `MIO_DIR_RESET;
      dir5_q <= `MIO_DIR_RESET;
      dir7_q <= `MIO_DIR_RESET;
    end else if (wr_en) begin
      if (addr_is(cap_q.addr, `MIO_IDX_PORT4_DIR)) dir4_q <= wd | ~`MIO_PORT4_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT5_DIR)) dir5_q <= wd | ~`MIO_PORT5_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT7_DIR)) dir7_q <= wd | ~`MIO_PORT7_IMPL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pull4_q <= `MIO_CFG_RESET;
      pull5_q <= `MIO_CFG_RESET;
      pull7_q <= `MIO_CFG_RESET;
    end else if (wr_en) begin
      if (addr_is(cap_q.addr, `MIO_IDX_PORT4_PULLUP)) pull4_q <= wd & `MIO_PORT4_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT5_PULLUP)) pull5_q <= wd & `MIO_PORT5_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT7_PULLUP)) pull7_q <= wd & `MIO_PORT7_IMPL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ana4_q <= `MIO_CFG_RESET;
      ana5_q <= `MIO_CFG_RESET;
      ana7_q <= `MIO_CFG_RESET;
    end else if (wr_en) begin
      if (addr_is(cap_q.addr, `MIO_IDX_PORT4_ANALOG)) ana4_q <= wd & `MIO_PORT4_ANA_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT5_ANALOG)) ana5_q <= wd & `MIO_PORT5_ANA_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_PORT7_ANALOG)) ana7_q <= wd & `MIO_PORT7_ANA_IMPL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      od5_q  <= `MIO_CFG_RESET;
      edge_q <= `MIO_CFG_RESET;
      mask_q <= `MIO_CFG_RESET;
    end else if (wr_en) begin
      if (addr_is(cap_q.addr, `MIO_IDX_PORT5_OPEN_DRN)) od5_q <= wd & `MIO_PORT5_OD_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_IRQ_EDGE)) edge_q <= wd & `MIO_EDGE_IMPL;
      if (addr_is(cap_q.addr, `MIO_IDX_IRQ_MASK)) mask_q <= wd & `MIO_IRQ_IMPL;
    end
  end

  // Pin levels are asynchronous to clk_sys
  mio_pin_sync #(
    .W (9)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   ({port7_pin_in, port5_pin_in, port4_pin_in}),
    .pin_sync (pin_sync)
  );

  // Analog pins read as low on the digital side
  assign din4 = {5'h00, pin_sync[2:0]} & ~ana4_q;
  assign din5 = {6'h00, pin_sync[4:3]} & ~ana5_q;
  assign din7 = {4'h0, pin_sync[8:5]} & ~ana7_q;

  mio_edge_irq #(
    .N (2)
  ) u_edge (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .level       (din5[1:0]),
    .edge_sel    (edge_q[3:0]),
    .event_pulse (port5_event)
  );

  // An edge in the clearing cycle keeps its flag set
  assign stat_clr = (wr_en && addr_is(cap_q.addr, `MIO_IDX_IRQ_STATUS)) ? wd : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_q <= 8'h00;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | {6'h00, port5_event};
      irq_q  <= |(stat_q & mask_q);
    end
  end

  assign drv4 = pin_drive(dir4_q, ana4_q, latch4_q, 8'h00, pull4_q);
  assign drv5 = pin_drive(dir5_q, ana5_q, latch5_q, od5_q, pull5_q);
  assign drv7 = pin_drive(dir7_q, ana7_q, latch7_q, 8'h00, pull7_q);

  // Pin controls registered; reset releases every pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port4_out_q <= '0;
      port4_oe_q  <= '0;
      port4_pu_q  <= '0;
      port4_ana_q <= '0;
      port5_out_q <= '0;
      port5_oe_q  <= '0;
      port5_pu_q  <= '0;
      port5_ana_q <= '0;
      port7_out_q <= '0;
      port7_oe_q  <= '0;
      port7_pu_q  <= '0;
      port7_ana_q <= '0;
    end else begin
      port4_out_q <= drv4.out[2:0];
      port4_oe_q  <= drv4.oe[2:0];
      port4_pu_q  <= drv4.pu[2:0];
      port4_ana_q <= ana4_q[2:0];
      port5_out_q <= drv5.out[1:0];
      port5_oe_q  <= drv5.oe[1:0];
      port5_pu_q  <= drv5.pu[1:0];
      port5_ana_q <= ana5_q[1:0];
      port7_out_q <= drv7.out[3:0];
      port7_oe_q  <= drv7.oe[3:0];
      port7_pu_q  <= drv7.pu[3:0];
      port7_ana_q <= ana7_q[3:0];
    end
  end

  assign hrdata          = hrdata_q;
  assign hreadyout       = hreadyout_q;
  assign hresp           = hresp_q;
  assign irq             = irq_q;
  assign port4_pin_out   = port4_out_q;
  assign port4_pin_oe    = port4_oe_q;
  assign port4_pullup_en = port4_pu_q;
  assign port4_analog_en = port4_ana_q;
  assign port5_pin_out   = port5_out_q;
  assign port5_pin_oe    = port5_oe_q;
  assign port5_pullup_en = port5_pu_q;
  assign port5_analog_en = port5_ana_q;
  assign port7_pin_out   = port7_out_q;
  assign port7_pin_oe    = port7_oe_q;
  assign port7_pullup_en = port7_pu_q;
  assign port7_analog_en = port7_ana_q;

  AST_PORT4_LATCH_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
    !dir4_q[0] |=> port4_oe_q[0] && (port4_out_q[0] == $past(latch4_q[0])))
    else $error("port 4 pin 0 not driven from latch");
  AST_PORT4_INPUT_RELEASE: assert property (@(posedge clk_sys) disable iff (rst)
    dir4_q[2] |=> !port4_oe_q[2])
    else $error("port 4 input pin driven");
  AST_PORT4_PULLUP: assert property (@(posedge clk_sys) disable iff (rst)
    (pull4_q[1] && dir4_q[1] && !ana4_q[1]) |=> port4_pu_q[1])
    else $error("port 4 pull-up not applied");
  AST_PORT4_ANALOG: assert property (@(posedge clk_sys) disable iff (rst)
    port4_ana_q[1] |-> !port4_oe_q[1] && !port4_pu_q[1])
    else $error("port 4 analog pin still digital");
  AST_PORT4_RESET: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rst) |-> (port4_oe_q == 3'h0) && (dir4_q == `MIO_DIR_RESET))
    else $error("port 4 not input after reset");
  AST_PORT5_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
    (!dir5_q[1] && !ana5_q[1]) |=> port5_oe_q[1] && (port5_out_q[1] == $past(latch5_q[1])))
    else $error("port 5 pin 1 not driven");
  AST_PORT5_PULLUP: assert property (@(posedge clk_sys) disable iff (rst)
    !dir5_q[0] |=> !port5_pu_q[0])
    else $error("port 5 pull-up on output pin");
  AST_PORT5_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (rst)
    (od5_q[0] && latch5_q[0]) |=> !port5_oe_q[0] && !port5_out_q[0])
    else $error("port 5 open drain drives high");
  AST_PORT5_ANALOG: assert property (@(posedge clk_sys) disable iff (rst)
    port5_ana_q[0] |-> !port5_oe_q[0])
    else $error("port 5 analog pin driven");
  AST_PORT5_RESET: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rst) |-> (port5_oe_q == 2'h0) && (stat_q == 8'h00))
    else $error("port 5 not input after reset");
  AST_PORT5_EDGE_RISE: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(din5[0]) && edge_q[`MIO_EDGE_RISE_BIT]) |-> ##[1:2] stat_q[0])
    else $error("rising edge lost");
  AST_PORT5_EDGE_FALL: assert property (@(posedge clk_sys) disable iff (rst)
    ($fell(din5[1]) && edge_q[2+`MIO_EDGE_FALL_BIT]) |-> ##[1:2] stat_q[1])
    else $error("falling edge lost");
  AST_PORT7_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
    (!dir7_q[3]) |=> port7_oe_q[3] && (port7_out_q[3] == $past(latch7_q[3])))
    else $error("port 7 pin 3 not driven");
  AST_PORT7_PULLUP: assert property (@(posedge clk_sys) disable iff (rst)
    (pull7_q[2] && dir7_q[2]) |=> port7_pu_q[2])
    else $error("port 7 pull-up not applied");
  AST_PORT7_ANALOG: assert property (@(posedge clk_sys) disable iff (rst)
    ana7_q[0] |=> port7_ana_q[0] && !port7_oe_q[0] && !port7_pu_q[0])
    else $error("port 7 analog pin still digital");
  AST_PORT7_RESET: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rst) |-> (port7_oe_q == 4'h0) && (port7_pu_q == 4'h0))
    else $error("port 7 not input after reset");

endmodule

// ===== mio_board.sv
`timescale 1ns/100ps

module mio_board #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] drv_en,
  input  wire logic [W-1:0] drv_val,
  output logic      [W-1:0] pin
);
  logic flt_q = 1'b0;

  // Undriven pin must not look settled, so it toggles every cycle
  always_ff @(posedge clk_sys) begin
    flt_q <= ~flt_q;
  end

  // Device driver wins, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i])
        pin[i] = out[i];
      else if (drv_en[i])
        pin[i] = drv_val[i];
      else if (pu[i])
        pin[i] = 1'b1;
      else
        pin[i] = flt_q ^ i[0];
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/100ps
`include "mio_map.svh"

module tb;
  import mio_pkg::*;
  localparam logic [19:0] LAT[3] = '{`MIO_IDX_PORT4_LATCH, `MIO_IDX_PORT5_LATCH, `MIO_IDX_PORT7_LATCH};
  localparam logic [19:0] DIR[3] = '{`MIO_IDX_PORT4_DIR, `MIO_IDX_PORT5_DIR, `MIO_IDX_PORT7_DIR};
  localparam logic [19:0] PUR[3] = '{`MIO_IDX_PORT4_PULLUP, `MIO_IDX_PORT5_PULLUP, `MIO_IDX_PORT7_PULLUP};
  localparam logic [19:0] ANA[3] = '{`MIO_IDX_PORT4_ANALOG, `MIO_IDX_PORT5_ANALOG, `MIO_IDX_PORT7_ANALOG};
  localparam logic [7:0]  IMP[3] = '{`MIO_PORT4_IMPL, `MIO_PORT5_IMPL, `MIO_PORT7_IMPL};
  localparam logic [7:0]  AIM[3] = '{`MIO_PORT4_ANA_IMPL, `MIO_PORT5_ANA_IMPL, `MIO_PORT7_ANA_IMPL};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [2:0]  port4_in, port4_out, port4_oe, port4_pu, port4_an;
  logic [1:0]  port5_in, port5_out, port5_oe, port5_pu, port5_an;
  logic [3:0]  port7_in, port7_out, port7_oe, port7_pu, port7_an;
  logic [7:0]  drv_en[3];
  logic [7:0]  drv_val[3];
  logic [7:0]  oe_v[3];
  logic [7:0]  out_v[3];
  logic [7:0]  pu_v[3];
  logic [7:0]  an_v[3];
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;

  assign oe_v  = '{8'(port4_oe), 8'(port5_oe), 8'(port7_oe)};
  assign out_v = '{8'(port4_out), 8'(port5_out), 8'(port7_out)};
  assign pu_v  = '{8'(port4_pu), 8'(port5_pu), 8'(port7_pu)};
  assign an_v  = '{8'(port4_an), 8'(port5_an), 8'(port7_an)};

  always #2 clk_sys = ~clk_sys;

  mio_ports mio_ports_inst (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq,
    .port4_pin_in(port4_in), .port4_pin_out(port4_out), .port4_pin_oe(port4_oe),
    .port4_pullup_en(port4_pu), .port4_analog_en(port4_an),
    .port5_pin_in(port5_in), .port5_pin_out(port5_out), .port5_pin_oe(port5_oe),
    .port5_pullup_en(port5_pu), .port5_analog_en(port5_an),
    .port7_pin_in(port7_in), .port7_pin_out(port7_out), .port7_pin_oe(port7_oe),
    .port7_pullup_en(port7_pu), .port7_analog_en(port7_an));

  mio_board #(.W(3)) mio_board_port4_inst (.clk_sys, .oe(port4_oe), .out(port4_out), .pu(port4_pu),
    .drv_en(drv_en[0][2:0]), .drv_val(drv_val[0][2:0]), .pin(port4_in));
  mio_board #(.W(2)) mio_board_port5_inst (.clk_sys, .oe(port5_oe), .out(port5_out), .pu(port5_pu),
    .drv_en(drv_en[1][1:0]), .drv_val(drv_val[1][1:0]), .pin(port5_in));
  mio_board #(.W(4)) mio_board_port7_inst (.clk_sys, .oe(port7_oe), .out(port7_out), .pu(port7_pu),
    .drv_en(drv_en[2][3:0]), .drv_val(drv_val[2][3:0]), .pin(port7_in));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task summarize;
    $display("err_total=%0d tests_run=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One single transfer; the next may start at the completing edge
  task automatic bus(input logic [19:0] idx, input logic wr_en, input logic [7:0] wd);
    hsel   <= 1'b1;
    haddr  <= {10'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr_en;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= 32'(wd);
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rdc(input string name, input logic [19:0] idx, input logic [31:0] exp, input logic [31:0] m);
    bus(idx, 1'b0, 8'h0);
    check(name, rd & m, exp);
    check("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic [7:0] exp_read(input logic [7:0] dir, lat, ext, imp);
    return ((dir & ext) | (~dir & lat)) & imp;
  endfunction

  // Drive pin5 levels, then see status and irq follow the selected edge
  task automatic edge_chk(input logic [1:0] v, input logic [1:0] exp);
    drv_val[1] <= 8'(v);
    tick(8);
    check("irq", 32'(irq), 32'(|exp));
    rdc("status", `MIO_IDX_IRQ_STATUS, 32'(exp), 32'h3);
    wr(`MIO_IDX_IRQ_STATUS, 8'h03);
    tick(3);
    check("irq_clr", 32'(irq), 32'h0);
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    logic [7:0] dir, lat, pu, ext;
    int p;
    for (int i = 0; i < 3; i++) begin
      drv_en[i]  = 8'h0;
      drv_val[i] = 8'h0;
    end
    void'($urandom(48));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 3; i++) begin
      check("oe_rst", 32'(oe_v[i]), 32'h0);
      rdc("dir_rst", DIR[i], 32'hff, 32'hff);
    end
    rdc("unmapped", 20'hfff30, 32'h0, 32'hffffffff);
    for (int i = 0; i < 30; i++) begin
      p   = i % 3;
      dir = 8'($urandom);
      lat = 8'($urandom);
      pu  = 8'($urandom);
      ext = 8'($urandom);
      drv_en[p]  <= dir & IMP[p];
      drv_val[p] <= ext;
      wr(DIR[p], dir);
      wr(LAT[p], lat);
      wr(PUR[p], pu);
      tick(3);
      check("oe", 32'(oe_v[p]), 32'(~dir & IMP[p]));
      check("out", 32'(out_v[p] & ~dir & IMP[p]), 32'(lat & ~dir & IMP[p]));
      check("pullup", 32'(pu_v[p]), 32'(pu & dir & IMP[p]));
      rdc("data", LAT[p], 32'(exp_read(dir, lat, ext, IMP[p])), 32'(IMP[p]));
    end
    for (p = 0; p < 3; p++) begin
      drv_en[p]  <= 8'hff;
      drv_val[p] <= 8'hff;
      wr(DIR[p], 8'hff);
      wr(PUR[p], 8'hff);
      wr(ANA[p], 8'hff);
      tick(3);
      check("analog", 32'(an_v[p]), 32'(AIM[p]));
      check("an_pu", 32'(pu_v[p]), 32'(IMP[p] & ~AIM[p]));
      rdc("an_data", LAT[p], 32'(IMP[p] & ~AIM[p]), 32'(IMP[p]));
      wr(ANA[p], 8'h00);
      tick(3);
      check("digital", 32'(an_v[p] | ~pu_v[p] & IMP[p]), 32'h0);
    end
    // Open-drain pin releases on a one and sinks on a zero
    drv_en[1] <= 8'h0;
    wr(`MIO_IDX_PORT5_DIR, 8'hfe);
    wr(`MIO_IDX_PORT5_OPEN_DRN, 8'h01);
    wr(`MIO_IDX_PORT5_LATCH, 8'h01);
    tick(3);
    check("od_hi", 32'(oe_v[1]), 32'h0);
    wr(`MIO_IDX_PORT5_LATCH, 8'h00);
    tick(3);
    check("od_lo", 32'({oe_v[1][0], out_v[1][0]}), 32'h2);
    wr(`MIO_IDX_PORT5_OPEN_DRN, 8'h00);
    wr(`MIO_IDX_PORT5_LATCH, 8'h01);
    tick(3);
    check("pp_hi", 32'({oe_v[1][0], out_v[1][0]}), 32'h3);
    wr(`MIO_IDX_PORT5_DIR, 8'hff);
    drv_en[1]  <= 8'h03;
    drv_val[1] <= 8'h00;
    wr(`MIO_IDX_IRQ_MASK, 8'h03);
    tick(4);
    wr(`MIO_IDX_IRQ_STATUS, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(`MIO_IDX_IRQ_EDGE, 8'(m));
      edge_chk(2'b01, 2'(m & 1));
      edge_chk(2'b00, 2'(m >> 1));
    end
    wr(`MIO_IDX_IRQ_MASK, 8'h00);
    wr(`MIO_IDX_IRQ_EDGE, 8'h03);
    drv_val[1] <= 8'h01;
    tick(8);
    check("irq_masked", 32'(irq), 32'h0);
    rdc("st_masked", `MIO_IDX_IRQ_STATUS, 32'h1, 32'h3);
    wr(`MIO_IDX_IRQ_MASK, 8'h03);
    wr(`MIO_IDX_IRQ_STATUS, 8'h03);
    wr(`MIO_IDX_IRQ_EDGE, 8'h04);
    edge_chk(2'b11, 2'b10);
    wr(`MIO_IDX_IRQ_EDGE, 8'h08);
    edge_chk(2'b01, 2'b10);
    summarize();
  end
endmodule
